// >>> hw/esr_pkg.sv
// Shared constants and types for the eSPI slave reset and event control block.
// Overview of operation
// - Link clock comes from host, max 51 MHz.
// - Internal logic runs from the main clock.
// - Power-on reset clears flags, config and state, asserts resets.
// - Bus reset follows reset pin and power-on.
// - Bus reset releases all bus pins.
// - Bus reset abandons transactions, flushes FIFOs.
// - Bus reset clears flags, keeps only reset interrupt.
// - Bus reset defaults config, keeps capability fields.
// - Main-power reset while main rail is off.
// - Host-interface reset on power off or host.
// - Platform reset from wire, resets, power, disable.
// - Reset-warn wire edge raises firmware interrupt.
// - Host waits for acknowledge after raising warn.
// - Stop bus mastering, wait both busy clear.
// - Stop latency messages, wait transmit busy clear.
// - Block new side-band and IRQ wire edges.
// - Acknowledge last; host then drives platform reset.
// - Traffic raises a wake-only event.
// - Separate interrupt per channel to aggregator.
// - Forty wire interrupts, ten groups of four.
// - Reset interrupt on both pin edges.
// - Stay passive on pins while reset low.
package esr_pkg;
	// Nominal main clock of the real part; the bench runs the block at 50 MHz.
	localparam int MAIN_CLK_MHZ     = 48;
	localparam int LINK_CLK_MAX_MHZ = 51;
	localparam int REF_CLK_MHZ      = 50;

	localparam int CHAN_IRQ_N = 7;
	localparam int VW_GROUPS  = 10;
	localparam int VW_SOURCES = 4;
	localparam int VW_IRQ_N   = VW_GROUPS * VW_SOURCES;

	localparam int         CFG_W       = 8;
	localparam logic [7:0] CFG_RST_VAL = 8'h00;
	// Bits loaded from capability registers survive a bus reset.
	localparam logic [7:0] CFG_CAP_MASK = 8'hF0;

	localparam logic RST_FLAG_ON  = 1'b1;
	localparam logic RST_FLAG_OFF = 1'b0;

	typedef struct packed {
		logic periph;
		logic busmaster1;
		logic busmaster2;
		logic latency_msg;
		logic oob_up;
		logic oob_down;
		logic flash;
	} esr_chan_t;

	typedef struct packed {
		logic busmaster1_busy;
		logic busmaster2_busy;
		logic ltr_tx_busy;
	} esr_busy_t;

	typedef enum logic [1:0] {
		ACK_IDLE    = 2'b00,
		ACK_QUIESCE = 2'b01,
		ACK_DRAIN   = 2'b10,
		ACK_DONE    = 2'b11
	} esr_ack_state_t;
endpackage

// >>> hw/esr_sync.sv
// Two-stage synchroniser for a vector of levels from outside the clock domain.
`timescale 1ns/100ps
module esr_sync #(
	parameter int         W       = 1,
	parameter logic [0:0] RST_VAL = 1'b0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= {W{RST_VAL}};
			sync_r <= {W{RST_VAL}};
		end
		else
		begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule

// >>> hw/esr_flag_bank.sv
// Bank of sticky interrupt flags with set-over-clear and a hold-clear input.
`timescale 1ns/100ps
module esr_flag_bank #(
	parameter int W = 7
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         hold_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] flag_o
);
	logic [W-1:0] flag_r;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_flag
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					flag_r[g] <= 1'b0;
				else if (hold_i)
					flag_r[g] <= 1'b0;
				else if (set_i[g])
					flag_r[g] <= 1'b1;
				else if (clr_i[g])
					flag_r[g] <= 1'b0;
			end
		end
	endgenerate

	assign flag_o = flag_r;

	a_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hold_i |=> flag_r == '0)
		else $error("flag set while held");
	a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!hold_i && set_i != '0) |=> (flag_r & $past(set_i)) == $past(set_i))
		else $error("flag set lost");
endmodule

// >>> hw/esr_top.sv
// Reset distribution, reset-warn handshake and interrupt events for the eSPI slave.
`timescale 1ns/100ps
module esr_top
	import esr_pkg::*;
(
	// Clock and power-on reset
	input  wire logic                  REF_CLK_I,
	input  wire logic                  RST_N_I,
	// Bus pins seen from outside
	input  wire logic                  BUS_RESET_IRQ_N_I,
	input  wire logic                  ESPI_CLK_I,
	input  wire logic                  ESPI_CS_N_I,
	// Power and host state
	input  wire logic                  MAIN_POWER_GOOD_I,
	input  wire logic                  HOST_IF_RESET_REQ_I,
	input  wire logic                  PERIPH_CHAN_EN_I,
	// Virtual wire levels from the wire channel
	input  wire logic                  PLATFORM_RESET_VW_N_I,
	input  wire logic                  HOST_RST_WARN_VW_I,
	// Firmware control
	input  wire logic                  FW_ACK_REQ_I,
	input  wire esr_busy_t             BUSY_I,
	input  wire logic                  CFG_WR_I,
	input  wire logic [CFG_W-1:0]      CFG_WDATA_I,
	input  wire logic                  BUS_RESET_IRQ_CLR_I,
	input  wire logic                  WARN_IRQ_CLR_I,
	// Channel events, one-cycle pulses, and their clears
	input  wire esr_chan_t             CHAN_EVT_I,
	input  wire esr_chan_t             CHAN_CLR_I,
	input  wire logic [VW_IRQ_N-1:0]   M2S_WIRE_EVT_I,
	input  wire logic [VW_IRQ_N-1:0]   M2S_WIRE_CLR_I,
	// Reset outputs
	output logic                       BUS_RESET_O,
	output logic                       MAIN_PWR_RESET_O,
	output logic                       HOST_IF_RESET_O,
	output logic                       PLATFORM_RESET_O,
	output logic                       FLUSH_O,
	output logic                       PIN_DRIVE_EN_O,
	// Handshake outputs
	output logic                       HOST_RST_ACK_O,
	output logic                       STOP_BUSMASTER_O,
	output logic                       STOP_LTR_O,
	output logic                       STOP_VW_EDGES_O,
	// Configuration
	output logic [CFG_W-1:0]           CFG_O,
	// Interrupts and wake to the aggregator
	output logic                       TRAFFIC_WAKE_EVENT_O,
	output logic                       BUS_RESET_IRQ_O,
	output logic                       HOST_RST_WARN_IRQ_O,
	output esr_chan_t                  CHAN_IRQ_O,
	output logic [VW_IRQ_N-1:0]        M2S_WIRE_IRQ_O
);
	logic           rst_pin_s;
	logic           rst_pin_e_s;
	logic           link_clk_s;
	logic           cs_n_s;
	logic           pwr_good_s;
	logic           host_if_s;
	logic           plt_vw_n_s;
	logic           warn_s;
	logic           rst_pin_d_r;
	logic           link_clk_d_r;
	logic           cs_n_d_r;
	logic           warn_d_r;
	logic           bus_reset_r;
	logic           bus_reset_nxt;
	logic           main_pwr_reset_r;
	logic           host_if_reset_r;
	logic           platform_reset_r;
	logic           flush_r;
	logic           pin_en_r;
	logic           ack_r;
	logic           stop_r;
	logic           traffic_r;
	logic           rst_irq_r;
	logic           warn_irq_r;
	logic [CFG_W-1:0] cfg_r;
	logic           rst_edge;
	logic           warn_edge;
	logic           link_rise;
	logic           cs_fall;
	logic           busy_any;
	esr_ack_state_t ack_state_r;
	esr_ack_state_t ack_state_nxt;

	esr_sync #(
		.W       (1),
		.RST_VAL (1'b0)
	) u_sync_lo (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     (BUS_RESET_IRQ_N_I),
		.q_o     (rst_pin_s)
	);

	// Power good and the platform wire start low so resets stay asserted.
	esr_sync #(
		.W       (5),
		.RST_VAL (1'b0)
	) u_sync_misc (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({ESPI_CLK_I, MAIN_POWER_GOOD_I, HOST_IF_RESET_REQ_I,
			PLATFORM_RESET_VW_N_I, HOST_RST_WARN_VW_I}),
		.q_o     ({link_clk_s, pwr_good_s, host_if_s, plt_vw_n_s, warn_s})
	);

	// The reset pin is synchronised once more with an idle-high start value for the
	// edge detector, so releasing power-on reset with the pin high never looks like a pin edge.
	esr_sync #(
		.W       (2),
		.RST_VAL (1'b1)
	) u_sync_cs (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({BUS_RESET_IRQ_N_I, ESPI_CS_N_I}),
		.q_o     ({rst_pin_e_s, cs_n_s})
	);

	// Delayed copies for edge detection; they read only the second stage.
	// main clock domain
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rst_pin_d_r  <= 1'b1;
			link_clk_d_r <= 1'b0;
			cs_n_d_r     <= 1'b1;
			warn_d_r     <= 1'b0;
		end
		else
		begin
			rst_pin_d_r  <= rst_pin_e_s;
			link_clk_d_r <= link_clk_s;
			cs_n_d_r     <= cs_n_s;
			warn_d_r     <= warn_s;
		end
	end

	assign rst_edge  = rst_pin_e_s ^ rst_pin_d_r;
	assign warn_edge = warn_s ^ warn_d_r;
	assign link_rise = link_clk_s & ~link_clk_d_r;
	assign cs_fall   = ~cs_n_s & cs_n_d_r;
	assign busy_any  = BUSY_I.busmaster1_busy | BUSY_I.busmaster2_busy
		| BUSY_I.ltr_tx_busy;

	assign bus_reset_nxt = ~rst_pin_s;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			bus_reset_r      <= 1'b1;
			pin_en_r         <= 1'b0;
			flush_r          <= 1'b0;
			main_pwr_reset_r <= 1'b1;
			host_if_reset_r  <= 1'b1;
			platform_reset_r <= 1'b1;
		end
		else
		begin
			bus_reset_r      <= bus_reset_nxt;
			pin_en_r         <= ~bus_reset_nxt;
			flush_r          <= bus_reset_nxt & ~bus_reset_r;
			main_pwr_reset_r <= ~pwr_good_s;
			host_if_reset_r  <= ~pwr_good_s | host_if_s;
			platform_reset_r <= bus_reset_nxt | ~pwr_good_s | ~PERIPH_CHAN_EN_I
				| ~plt_vw_n_s;
		end
	end

	// Only capability-loaded bits keep their value across a bus reset.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			cfg_r <= CFG_RST_VAL;
		else if (bus_reset_r)
			cfg_r <= (cfg_r & CFG_CAP_MASK) | (CFG_RST_VAL & ~CFG_CAP_MASK);
		else if (CFG_WR_I)
			cfg_r <= CFG_WDATA_I;
	end

	// The reset interrupt is the only flag that lives through a bus reset.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rst_irq_r <= RST_FLAG_OFF;
		else if (rst_edge)
			rst_irq_r <= RST_FLAG_ON;
		else if (BUS_RESET_IRQ_CLR_I)
			rst_irq_r <= RST_FLAG_OFF;
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			warn_irq_r <= RST_FLAG_OFF;
		else if (bus_reset_nxt)
			warn_irq_r <= RST_FLAG_OFF;
		else if (warn_edge)
			warn_irq_r <= RST_FLAG_ON;
		else if (WARN_IRQ_CLR_I)
			warn_irq_r <= RST_FLAG_OFF;
	end

	// The link clock is sampled, not used; above 25 MHz single edges can be
	// missed, but chip select falling alone is enough to flag traffic.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			traffic_r <= 1'b0;
		else
			traffic_r <= ~bus_reset_nxt & (cs_fall | (~cs_n_s & link_rise));
	end

	esr_flag_bank #(
		.W (CHAN_IRQ_N)
	) u_chan_flags (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.hold_i  (bus_reset_nxt),
		.set_i   (CHAN_EVT_I),
		.clr_i   (CHAN_CLR_I),
		.flag_o  (CHAN_IRQ_O)
	);

	esr_flag_bank #(
		.W (VW_IRQ_N)
	) u_wire_flags (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.hold_i  (bus_reset_nxt),
		.set_i   (M2S_WIRE_EVT_I),
		.clr_i   (M2S_WIRE_CLR_I),
		.flag_o  (M2S_WIRE_IRQ_O)
	);

	always_comb
	begin
		ack_state_nxt = ack_state_r;
		case (ack_state_r)
			ACK_IDLE:
				if (warn_s && FW_ACK_REQ_I)
					ack_state_nxt = ACK_QUIESCE;
			ACK_QUIESCE:
				if (!warn_s)
					ack_state_nxt = ACK_IDLE;
				else
					ack_state_nxt = ACK_DRAIN;
			ACK_DRAIN:
				if (!warn_s)
					ack_state_nxt = ACK_IDLE;
				else if (!busy_any)
					ack_state_nxt = ACK_DONE;
			ACK_DONE:
				if (!warn_s)
					ack_state_nxt = ACK_IDLE;
			default:
				ack_state_nxt = ACK_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			ack_state_r <= ACK_IDLE;
		else if (bus_reset_nxt)
			ack_state_r <= ACK_IDLE;
		else
			ack_state_r <= ack_state_nxt;
	end

	// Stopping stays on through the acknowledge, until warn falls.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			stop_r <= 1'b0;
			ack_r  <= 1'b0;
		end
		else
		begin
			stop_r <= ~bus_reset_nxt & (ack_state_nxt != ACK_IDLE);
			ack_r  <= ~bus_reset_nxt & (ack_state_nxt == ACK_DONE);
		end
	end

	assign BUS_RESET_O          = bus_reset_r;
	assign MAIN_PWR_RESET_O     = main_pwr_reset_r;
	assign HOST_IF_RESET_O      = host_if_reset_r;
	assign PLATFORM_RESET_O     = platform_reset_r;
	assign FLUSH_O              = flush_r;
	assign PIN_DRIVE_EN_O       = pin_en_r;
	assign HOST_RST_ACK_O       = ack_r;
	assign STOP_BUSMASTER_O     = stop_r;
	assign STOP_LTR_O           = stop_r;
	assign STOP_VW_EDGES_O      = stop_r;
	assign CFG_O                = cfg_r;
	assign TRAFFIC_WAKE_EVENT_O = traffic_r;
	assign BUS_RESET_IRQ_O      = rst_irq_r;
	assign HOST_RST_WARN_IRQ_O  = warn_irq_r;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_drain_done;
		ack_state_r == ACK_DRAIN && warn_s && !busy_any && !bus_reset_nxt;
	endsequence

	sequence s_acked;
		ack_r && stop_r;
	endsequence

	a_bus_rst_pin: assert property ($fell(BUS_RESET_IRQ_N_I) |-> ##[3:4] BUS_RESET_O)
		else $error("bus reset late after pin low");
	a_pins_passive: assert property (BUS_RESET_O |-> !PIN_DRIVE_EN_O)
		else $error("pins driven in bus reset");
	a_rst_irq_edge: assert property ($changed(rst_pin_e_s) |=> BUS_RESET_IRQ_O)
		else $error("reset interrupt missed");
	a_flags_quiet: assert property (bus_reset_r |-> CHAN_IRQ_O == '0
		&& M2S_WIRE_IRQ_O == '0 && !HOST_RST_WARN_IRQ_O)
		else $error("flag active during bus reset");
	a_flush_pulse: assert property ($rose(bus_reset_r) |-> FLUSH_O ##1 !FLUSH_O)
		else $error("flush not a single pulse");
	a_cfg_keep: assert property (bus_reset_r |=>
		(cfg_r & CFG_CAP_MASK) == ($past(cfg_r) & CFG_CAP_MASK))
		else $error("capability bits lost");
	a_plat_rst_src: assert property ((bus_reset_nxt || !pwr_good_s || !PERIPH_CHAN_EN_I
		|| !plt_vw_n_s)
		|=> PLATFORM_RESET_O)
		else $error("platform reset not asserted");
	a_warn_irq: assert property ((warn_edge && !bus_reset_nxt) |=> HOST_RST_WARN_IRQ_O)
		else $error("warn interrupt missed");
	a_ack_after_drain: assert property (s_drain_done |=> s_acked)
		else $error("acknowledge not given after drain");
	a_ack_needs_idle: assert property ($rose(ack_r) |-> !$past(busy_any)
		&& $past(stop_r, 2))
		else $error("acknowledge before quiesce");
	a_pwr_resets: assert property (!pwr_good_s |=> MAIN_PWR_RESET_O && HOST_IF_RESET_O)
		else $error("power resets missing");
endmodule

// >>> test/esr_host_model.sv
// Host-side model: reset pin, framed link clock, chip select and virtual wires.
`timescale 1ns/100ps
module esr_host_model (
	// Clock
	input  wire logic clk_i,
	// Acknowledge wire from the slave
	input  wire logic ack_i,
	// Pins and wires toward the slave
	output logic      bus_reset_irq_n_o,
	output logic      espi_clk_o,
	output logic      cs_n_o,
	output logic      plt_rst_n_o,
	output logic      warn_o
);
	logic frame_on;

	initial
	begin
		bus_reset_irq_n_o = 1'b1;
		espi_clk_o     = 1'b0;
		cs_n_o         = 1'b1;
		plt_rst_n_o    = 1'b1;
		warn_o         = 1'b0;
		frame_on       = 1'b0;
	end

	// The offset keeps link edges away from main clock edges, as a real host would.
	// link clock rate
	initial
	begin
		#3;
		forever
		begin
			#80;
			espi_clk_o = frame_on ? ~espi_clk_o : 1'b0;
		end
	end

	// Platform reset is never driven before the acknowledge, and is released with the warning.
	// acknowledge first
	always @(posedge clk_i)
	begin
		if (warn_o && ack_i)
			plt_rst_n_o <= 1'b0;
		else if (!warn_o)
			plt_rst_n_o <= 1'b1;
	end

	task automatic set_pin(input logic v);
		@(posedge clk_i);
		bus_reset_irq_n_o <= v;
	endtask

	task automatic set_warn(input logic v);
		@(posedge clk_i);
		warn_o <= v;
	endtask

	task automatic frame(input int n);
		@(posedge clk_i);
		cs_n_o   <= 1'b0;
		frame_on = 1'b1;
		repeat (n) @(posedge clk_i);
		frame_on = 1'b0;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
	endtask
endmodule

// >>> test/esr_top_tb.sv
// Self-checking bench for the eSPI slave reset and event control block.
`timescale 1ns/100ps
module esr_top_tb
	import esr_pkg::*;
;
	logic                clk, rst_n, pg, hreq, pen, fwack, cwr, rclr, wclr;
	logic                epin, eclk, csn, pltn, warn;
	logic                brst, mrst, hrst, prst, flush, pinen, ack, sbm, sltr, svw;
	logic                wake, rirq, wirq;
	logic [CFG_W-1:0]    cwd, cfg;
	esr_busy_t           busy;
	esr_chan_t           cev, ccl, cirq;
	logic [VW_IRQ_N-1:0] wev, wcl, mirq;
	int                  compares, miscompares, flush_cnt, wake_cnt;

	esr_host_model u_host (
		.clk_i(clk), .ack_i(ack), .bus_reset_irq_n_o(epin), .espi_clk_o(eclk),
		.cs_n_o(csn), .plt_rst_n_o(pltn), .warn_o(warn)
	);

	esr_top u_dut (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .BUS_RESET_IRQ_N_I(epin), .ESPI_CLK_I(eclk),
		.ESPI_CS_N_I(csn), .MAIN_POWER_GOOD_I(pg), .HOST_IF_RESET_REQ_I(hreq),
		.PERIPH_CHAN_EN_I(pen), .PLATFORM_RESET_VW_N_I(pltn), .HOST_RST_WARN_VW_I(warn),
		.FW_ACK_REQ_I(fwack), .BUSY_I(busy), .CFG_WR_I(cwr), .CFG_WDATA_I(cwd),
		.BUS_RESET_IRQ_CLR_I(rclr), .WARN_IRQ_CLR_I(wclr), .CHAN_EVT_I(cev),
		.CHAN_CLR_I(ccl), .M2S_WIRE_EVT_I(wev), .M2S_WIRE_CLR_I(wcl),
		.BUS_RESET_O(brst), .MAIN_PWR_RESET_O(mrst), .HOST_IF_RESET_O(hrst),
		.PLATFORM_RESET_O(prst), .FLUSH_O(flush), .PIN_DRIVE_EN_O(pinen),
		.HOST_RST_ACK_O(ack), .STOP_BUSMASTER_O(sbm), .STOP_LTR_O(sltr),
		.STOP_VW_EDGES_O(svw), .CFG_O(cfg), .TRAFFIC_WAKE_EVENT_O(wake),
		.BUS_RESET_IRQ_O(rirq), .HOST_RST_WARN_IRQ_O(wirq), .CHAN_IRQ_O(cirq),
		.M2S_WIRE_IRQ_O(mirq)
	);

	always #10 clk = ~clk;

	// Pulses are counted on every rising clock edge so a one-cycle output cannot slip between two checks.
	always @(posedge clk)
	begin
		flush_cnt <= flush_cnt + int'(flush === 1'b1);
		wake_cnt  <= wake_cnt + int'(wake === 1'b1);
	end

	task automatic wrap_up;
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic ev(input logic [6:0] c, input logic [VW_IRQ_N-1:0] w);
		@(posedge clk);
		cev <= c;
		wev <= w;
		@(posedge clk);
		cev <= '0;
		wev <= '0;
		#1;
	endtask

	task automatic clr(input logic [6:0] c, input logic [VW_IRQ_N-1:0] w, input logic r,
		input logic n);
		@(posedge clk);
		ccl  <= c;
		wcl  <= w;
		rclr <= r;
		wclr <= n;
		@(posedge clk);
		ccl  <= '0;
		wcl  <= '0;
		rclr <= 1'b0;
		wclr <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		cwr <= 1'b1;
		cwd <= d;
		@(posedge clk);
		cwr <= 1'b0;
		#1;
	endtask

	task automatic t_por;
		chk({brst, mrst, hrst, prst, pinen, cfg}, {4'hF, 1'b0, 8'h00});
		@(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
		chk({brst, mrst, hrst, prst, pinen, rirq, wirq}, 7'h04);
		chk({cirq, mirq}, 47'h0);
	endtask

	task automatic t_flags;
		for (int i = 0; i < CHAN_IRQ_N; i++)
		begin
			ev(7'h01 << i, '0);
			chk(cirq, 7'h01 << i);
			clr(7'h01 << i, '0, 1'b0, 1'b0);
			chk(cirq, 7'h00);
		end
		for (int i = 0; i < VW_IRQ_N; i++)
		begin
			ev(7'h00, 40'h1 << i);
			chk(mirq, 40'h1 << i);
			clr(7'h00, 40'h1 << i, 1'b0, 1'b0);
			chk(mirq, 40'h0);
		end
	endtask

	task automatic t_bus;
		int f0;
		wr(8'hFF);
		ev(7'h7F, '1);
		chk(cfg, 8'hFF);
		f0 = flush_cnt;
		u_host.set_pin(1'b0);
		cyc(4);
		chk({brst, pinen, prst, rirq}, 4'hB);
		chk({cirq, mirq, cfg}, {47'h0, 8'hF0});
		chk(flush_cnt - f0, 1);
		ev(7'h7F, '1);
		wr(8'h0F);
		chk({cirq, mirq, cfg}, {47'h0, 8'hF0});
		clr(7'h00, '0, 1'b1, 1'b0);
		chk(rirq, 1'b0);
		u_host.set_pin(1'b1);
		cyc(4);
		chk({brst, pinen, rirq}, 3'h3);
		clr(7'h00, '0, 1'b1, 1'b0);
		chk(rirq, 1'b0);
	endtask

	task automatic t_pwr;
		@(posedge clk);
		pg <= 1'b0;
		cyc(4);
		chk({mrst, hrst, prst, brst}, 4'hE);
		@(posedge clk);
		pg   <= 1'b1;
		hreq <= 1'b1;
		cyc(4);
		chk({mrst, hrst, prst, brst}, 4'h4);
		@(posedge clk);
		hreq <= 1'b0;
		pen  <= 1'b0;
		cyc(4);
		chk({mrst, hrst, prst, brst}, 4'h2);
		@(posedge clk);
		pen <= 1'b1;
		cyc(4);
		chk({mrst, hrst, prst, brst}, 4'h0);
	endtask

	task automatic t_hs;
		@(posedge clk);
		busy  <= 3'h7;
		fwack <= 1'b1;
		cyc(4);
		chk({sbm, sltr, svw, ack}, 4'h0);
		u_host.set_warn(1'b1);
		cyc(5);
		chk({wirq, sbm, sltr, svw, ack}, 5'h1E);
		@(posedge clk);
		busy <= 3'h1;
		cyc(4);
		chk(ack, 1'b0);
		@(posedge clk);
		busy <= 3'h0;
		cyc(3);
		chk({ack, prst}, 2'h2);
		cyc(4);
		chk(prst, 1'b1);
		clr(7'h00, '0, 1'b0, 1'b1);
		chk(wirq, 1'b0);
		@(posedge clk);
		fwack <= 1'b0;
		u_host.set_warn(1'b0);
		cyc(8);
		chk({wirq, sbm, sltr, svw, ack, prst}, 6'h20);
	endtask

	task automatic t_wake;
		int w0;
		w0 = wake_cnt;
		cyc(20);
		chk(wake_cnt - w0, 0);
		u_host.frame(16);
		cyc(4);
		chk(wake_cnt != w0, 1'b1);
	endtask

	task automatic t_por2;
		wr(8'hA5);
		ev(7'h7F, '1);
		@(posedge clk);
		rst_n <= 1'b0;
		#2;
		chk({cirq, mirq, cfg, brst, prst}, {55'h0, 2'h3});
		@(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
		chk({brst, rirq, cfg}, 10'h000);
	endtask

	initial
	begin
		clk         = 1'b0;
		rst_n       = 1'b0;
		pg          = 1'b1;
		hreq        = 1'b0;
		pen         = 1'b1;
		fwack       = 1'b0;
		busy        = '0;
		cwr         = 1'b0;
		cwd         = '0;
		rclr        = 1'b0;
		wclr        = 1'b0;
		cev         = '0;
		ccl         = '0;
		wev         = '0;
		wcl         = '0;
		compares    = 0;
		miscompares = 0;
		flush_cnt   = 0;
		wake_cnt    = 0;
		cyc(12);
		t_por;
		t_flags;
		t_bus;
		t_pwr;
		t_hs;
		t_wake;
		t_por2;
		wrap_up;
	end

	initial
	begin
		#400000;
		miscompares++;
		wrap_up;
	end
endmodule
